// File: hw/ppfs_top.v
// Purpose: pin configuration and function select for ports 0, 2, 4, 6, 8 and c
// Assumes: 20 MHz sys_clk, async active-low rstn, classic wishbone slave
// Notes:   timer vector order is timers 0,1,4,5,6,7
//
// Notes on behaviour
// - port 6 two bits, own direction, pull-up
// - reset: port 6 inputs, pull-ups off
// - port 8 six bits, own direction, pull-up
// - reset: port 8 inputs, pull-ups off
// - port c bits 2..7, own direction, pull-up
// - reset: port c inputs, pull-ups off
// - serial tx drives pin: output plus mode
// - serial rx fed: input plus mode, pull-up
// - serial clock bidirectional via direction and mode
// - serial pins unselected act as port 2
// - timer event input: mode selects, direction input
// - timer output: modes select, direction output
// - timer pins in input allow pull-up
// - timer pins unselected act as port 0/4
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`default_nettype none
`include "ppfs_map.vh"

module ppfs_top #(
    parameter P0W = 4,
    parameter P2W = 6,
    parameter P4W = 2,
    parameter P6W = 2,
    parameter P8W = 6,
    parameter PCW = 6
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             rstn,
    // wishbone slave
    input  wire             wb_cyc_i,
    input  wire             wb_stb_i,
    input  wire             wb_we_i,
    input  wire [7:0]       wb_adr_i,
    input  wire [3:0]       wb_sel_i,
    input  wire [31:0]      wb_dat_i,
    output wire [31:0]      wb_dat_o,
    output wire             wb_ack_o,
    // port 0 pins
    input  wire [P0W-1:0]   port0_pin_in,
    output wire [P0W-1:0]   port0_pin_out,
    output wire [P0W-1:0]   port0_pin_oe,
    output wire [P0W-1:0]   port0_pin_pu,
    // port 2 pins
    input  wire [P2W-1:0]   port2_pin_in,
    output wire [P2W-1:0]   port2_pin_out,
    output wire [P2W-1:0]   port2_pin_oe,
    output wire [P2W-1:0]   port2_pin_pu,
    // port 4 pins
    input  wire [P4W-1:0]   port4_pin_in,
    output wire [P4W-1:0]   port4_pin_out,
    output wire [P4W-1:0]   port4_pin_oe,
    output wire [P4W-1:0]   port4_pin_pu,
    // port 6 pins
    input  wire [P6W-1:0]   port6_pin_in,
    output wire [P6W-1:0]   port6_pin_out,
    output wire [P6W-1:0]   port6_pin_oe,
    output wire [P6W-1:0]   port6_pin_pu,
    // port 8 pins
    input  wire [P8W-1:0]   port8_pin_in,
    output wire [P8W-1:0]   port8_pin_out,
    output wire [P8W-1:0]   port8_pin_oe,
    output wire [P8W-1:0]   port8_pin_pu,
    // port c pins, bit 0 of the vector is pin 2
    input  wire [PCW-1:0]   portc_pin_in,
    output wire [PCW-1:0]   portc_pin_out,
    output wire [PCW-1:0]   portc_pin_oe,
    output wire [PCW-1:0]   portc_pin_pu,
    // serial units
    input  wire             serial_tx_out_ch0,
    input  wire             serial_tx_out_ch1,
    output wire             serial_rx_in_ch0,
    output wire             serial_rx_in_ch1,
    input  wire             serial_clock_io_ch0_out,
    input  wire             serial_clock_io_ch1_out,
    output wire             serial_clock_io_ch0_in,
    output wire             serial_clock_io_ch1_in,
    // 8-bit timers 0,1,4,5,6,7
    input  wire [5:0]       timer_pulse_out,
    output wire [5:0]       timer_event_in
);

    // configuration registers
    reg  [P0W-1:0] port0_data_reg;
    reg  [P0W-1:0] port0_direction_reg;
    reg  [P0W-1:0] port0_pullup_select_reg;
    reg  [P0W-1:0] port0_mode_reg;
    reg  [P2W-1:0] port2_data_reg;
    reg  [P2W-1:0] port2_direction_reg;
    reg  [P2W-1:0] port2_pullup_select_reg;
    reg  [P2W-1:0] port2_mode_reg;
    reg  [P4W-1:0] port4_data_reg;
    reg  [P4W-1:0] port4_direction_reg;
    reg  [P4W-1:0] port4_pullup_select_reg;
    reg  [P4W-1:0] port4_mode1_reg;
    reg  [P4W-1:0] port4_mode2_reg;
    reg  [P6W-1:0] port6_data_reg;
    reg  [P6W-1:0] port6_direction_reg;
    reg  [P6W-1:0] port6_pullup_select_reg;
    reg  [P8W-1:0] port8_data_reg;
    reg  [P8W-1:0] port8_direction_reg;
    reg  [P8W-1:0] port8_pullup_select_reg;
    reg  [PCW-1:0] portc_data_reg;
    reg  [PCW-1:0] portc_direction_reg;
    reg  [PCW-1:0] portc_pullup_select_reg;
    reg  [31:0]    rd_data_reg;
    reg  [31:0]    rd_data_next;

    // bus strobes
    wire           bus_load;
    wire           bus_wr;

    // pin read values
    wire [P0W-1:0] port0_rd;
    wire [P2W-1:0] port2_rd;
    wire [P4W-1:0] port4_rd;
    wire [P6W-1:0] port6_rd;
    wire [P8W-1:0] port8_rd;
    wire [PCW-1:0] portc_rd;

    // alternate function plumbing
    wire [P2W-1:0] p2_osel;
    wire [P2W-1:0] p2_isel;
    wire [P2W-1:0] p2_alt_out;
    wire [P2W-1:0] p2_alt_in;
    wire [P4W-1:0] p4_osel;
    wire [P0W-1:0] p0_alt_in;
    wire [P4W-1:0] p4_alt_in;

    // zero-extend a port value into a bus word
    function [31:0] word_of;
        input [7:0] v;
        begin
            word_of = {24'h000000, v};
        end
    endfunction

    ppfs_wb_ack u_ack (
        .sys_clk(sys_clk), .rstn(rstn), .cyc(wb_cyc_i), .stb(wb_stb_i), .we(wb_we_i),
        .sel0(wb_sel_i[0]), .ack(wb_ack_o), .load(bus_load), .wr_en(bus_wr)
    );

    // register writes; reset leaves every pin an input, pull-up off
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            port0_data_reg <= {P0W{1'b0}};
            port0_direction_reg <= {P0W{1'b0}};
            port0_pullup_select_reg <= {P0W{1'b0}};
            port0_mode_reg <= {P0W{1'b0}};
            port2_data_reg <= {P2W{1'b0}};
            port2_direction_reg <= {P2W{1'b0}};
            port2_pullup_select_reg <= {P2W{1'b0}};
            port2_mode_reg <= {P2W{1'b0}};
            port4_data_reg <= {P4W{1'b0}};
            port4_direction_reg <= {P4W{1'b0}};
            port4_pullup_select_reg <= {P4W{1'b0}};
            port4_mode1_reg <= {P4W{1'b0}};
            port4_mode2_reg <= {P4W{1'b0}};
            port6_data_reg <= {P6W{1'b0}};
            port6_direction_reg <= {P6W{1'b0}};
            port6_pullup_select_reg <= {P6W{1'b0}};
            port8_data_reg <= {P8W{1'b0}};
            port8_direction_reg <= {P8W{1'b0}};
            port8_pullup_select_reg <= {P8W{1'b0}};
            portc_data_reg <= {PCW{1'b0}};
            portc_direction_reg <= {PCW{1'b0}};
            portc_pullup_select_reg <= {PCW{1'b0}};
        end else if (bus_wr) begin
            case (wb_adr_i)
                `PPFS_P0_OUT: port0_data_reg <= wb_dat_i[P0W-1:0];
                `PPFS_P0_DIR: port0_direction_reg <= wb_dat_i[P0W-1:0];
                `PPFS_P0_PLU: port0_pullup_select_reg <= wb_dat_i[P0W-1:0];
                `PPFS_P0_MD: port0_mode_reg <= wb_dat_i[P0W-1:0];
                `PPFS_P2_OUT: port2_data_reg <= wb_dat_i[P2W-1:0];
                `PPFS_P2_DIR: port2_direction_reg <= wb_dat_i[P2W-1:0];
                `PPFS_P2_PLU: port2_pullup_select_reg <= wb_dat_i[P2W-1:0];
                `PPFS_P2_MD: port2_mode_reg <= wb_dat_i[P2W-1:0];
                `PPFS_P4_OUT: port4_data_reg <= wb_dat_i[P4W-1:0];
                `PPFS_P4_DIR: port4_direction_reg <= wb_dat_i[P4W-1:0];
                `PPFS_P4_PLU: port4_pullup_select_reg <= wb_dat_i[P4W-1:0];
                `PPFS_P4_MD1: port4_mode1_reg <= wb_dat_i[P4W-1:0];
                `PPFS_P4_MD2: port4_mode2_reg <= wb_dat_i[P4W-1:0];
                `PPFS_P6_OUT: port6_data_reg <= wb_dat_i[P6W-1:0];
                `PPFS_P6_DIR: port6_direction_reg <= wb_dat_i[P6W-1:0];
                `PPFS_P6_PLU: port6_pullup_select_reg <= wb_dat_i[P6W-1:0];
                `PPFS_P8_OUT: port8_data_reg <= wb_dat_i[P8W-1:0];
                `PPFS_P8_DIR: port8_direction_reg <= wb_dat_i[P8W-1:0];
                `PPFS_P8_PLU: port8_pullup_select_reg <= wb_dat_i[P8W-1:0];
                `PPFS_PC_OUT: portc_data_reg <= wb_dat_i[`PPFS_PC_LSB+PCW-1:`PPFS_PC_LSB];
                `PPFS_PC_DIR: portc_direction_reg <= wb_dat_i[`PPFS_PC_LSB+PCW-1:`PPFS_PC_LSB];
                `PPFS_PC_PLU: portc_pullup_select_reg <=
                                  wb_dat_i[`PPFS_PC_LSB+PCW-1:`PPFS_PC_LSB];
                default: ;
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        rd_data_next = 32'h00000000;
        case (wb_adr_i)
            `PPFS_P0_OUT: rd_data_next = word_of({4'h0, port0_data_reg});
            `PPFS_P0_DIR: rd_data_next = word_of({4'h0, port0_direction_reg});
            `PPFS_P0_PLU: rd_data_next = word_of({4'h0, port0_pullup_select_reg});
            `PPFS_P0_IN:  rd_data_next = word_of({4'h0, port0_rd});
            `PPFS_P0_MD:  rd_data_next = word_of({4'h0, port0_mode_reg});
            `PPFS_P2_OUT: rd_data_next = word_of({2'h0, port2_data_reg});
            `PPFS_P2_DIR: rd_data_next = word_of({2'h0, port2_direction_reg});
            `PPFS_P2_PLU: rd_data_next = word_of({2'h0, port2_pullup_select_reg});
            `PPFS_P2_IN:  rd_data_next = word_of({2'h0, port2_rd});
            `PPFS_P2_MD:  rd_data_next = word_of({2'h0, port2_mode_reg});
            `PPFS_P4_OUT: rd_data_next = word_of({6'h00, port4_data_reg});
            `PPFS_P4_DIR: rd_data_next = word_of({6'h00, port4_direction_reg});
            `PPFS_P4_PLU: rd_data_next = word_of({6'h00, port4_pullup_select_reg});
            `PPFS_P4_IN:  rd_data_next = word_of({6'h00, port4_rd});
            `PPFS_P4_MD1: rd_data_next = word_of({6'h00, port4_mode1_reg});
            `PPFS_P4_MD2: rd_data_next = word_of({6'h00, port4_mode2_reg});
            `PPFS_P6_OUT: rd_data_next = word_of({6'h00, port6_data_reg});
            `PPFS_P6_DIR: rd_data_next = word_of({6'h00, port6_direction_reg});
            `PPFS_P6_PLU: rd_data_next = word_of({6'h00, port6_pullup_select_reg});
            `PPFS_P6_IN:  rd_data_next = word_of({6'h00, port6_rd});
            `PPFS_P8_OUT: rd_data_next = word_of({2'h0, port8_data_reg});
            `PPFS_P8_DIR: rd_data_next = word_of({2'h0, port8_direction_reg});
            `PPFS_P8_PLU: rd_data_next = word_of({2'h0, port8_pullup_select_reg});
            `PPFS_P8_IN:  rd_data_next = word_of({2'h0, port8_rd});
            `PPFS_PC_OUT: rd_data_next = word_of({portc_data_reg, 2'h0});
            `PPFS_PC_DIR: rd_data_next = word_of({portc_direction_reg, 2'h0});
            `PPFS_PC_PLU: rd_data_next = word_of({portc_pullup_select_reg, 2'h0});
            `PPFS_PC_IN:  rd_data_next = word_of({portc_rd, 2'h0});
            default:      rd_data_next = 32'h00000000;
        endcase
    end

    // read data captured in the cycle the request is first seen
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_reg <= 32'h00000000;
        end else if (bus_load) begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign wb_dat_o = rd_data_reg;

    // port 2: bits 0/3 tx, 1/4 clock, 2/5 rx
    assign p2_osel    = port2_mode_reg & 6'h1b;
    assign p2_isel    = port2_mode_reg & 6'h36;
    assign p2_alt_out = {1'b0, serial_clock_io_ch1_out, serial_tx_out_ch1,
                         1'b0, serial_clock_io_ch0_out, serial_tx_out_ch0};
    assign serial_rx_in_ch0       = p2_alt_in[2];
    assign serial_rx_in_ch1       = p2_alt_in[5];
    assign serial_clock_io_ch0_in = p2_alt_in[1];
    assign serial_clock_io_ch1_in = p2_alt_in[4];

    // timer output on port 4 needs both mode registers
    assign p4_osel        = port4_mode1_reg & port4_mode2_reg;
    assign timer_event_in = {p4_alt_in, p0_alt_in};

    ppfs_pad #(.W(P0W)) u_port0 (
        .dir(port0_direction_reg), .pu(port0_pullup_select_reg),
        .dout(port0_data_reg),
        .alt_osel(port0_mode_reg), .alt_isel(port0_mode_reg),
        .alt_out(timer_pulse_out[3:0]), .alt_in(p0_alt_in), .pin_in(port0_pin_in),
        .pin_out(port0_pin_out), .pin_oe(port0_pin_oe), .pin_pu(port0_pin_pu),
        .rd_val(port0_rd)
    );

    ppfs_pad #(.W(P2W)) u_port2 (
        .dir(port2_direction_reg), .pu(port2_pullup_select_reg),
        .dout(port2_data_reg),
        .alt_osel(p2_osel), .alt_isel(p2_isel), .alt_out(p2_alt_out), .alt_in(p2_alt_in),
        .pin_in(port2_pin_in), .pin_out(port2_pin_out), .pin_oe(port2_pin_oe),
        .pin_pu(port2_pin_pu), .rd_val(port2_rd)
    );

    ppfs_pad #(.W(P4W)) u_port4 (
        .dir(port4_direction_reg), .pu(port4_pullup_select_reg),
        .dout(port4_data_reg),
        .alt_osel(p4_osel), .alt_isel(port4_mode1_reg),
        .alt_out(timer_pulse_out[5:4]), .alt_in(p4_alt_in), .pin_in(port4_pin_in),
        .pin_out(port4_pin_out), .pin_oe(port4_pin_oe), .pin_pu(port4_pin_pu),
        .rd_val(port4_rd)
    );

    ppfs_pad #(.W(P6W)) u_port6 (
        .dir(port6_direction_reg), .pu(port6_pullup_select_reg),
        .dout(port6_data_reg), .alt_osel({P6W{1'b0}}), .alt_isel({P6W{1'b0}}),
        .alt_out({P6W{1'b0}}), .alt_in(), .pin_in(port6_pin_in), .pin_out(port6_pin_out),
        .pin_oe(port6_pin_oe), .pin_pu(port6_pin_pu), .rd_val(port6_rd)
    );

    ppfs_pad #(.W(P8W)) u_port8 (
        .dir(port8_direction_reg), .pu(port8_pullup_select_reg),
        .dout(port8_data_reg), .alt_osel({P8W{1'b0}}), .alt_isel({P8W{1'b0}}),
        .alt_out({P8W{1'b0}}), .alt_in(), .pin_in(port8_pin_in), .pin_out(port8_pin_out),
        .pin_oe(port8_pin_oe), .pin_pu(port8_pin_pu), .rd_val(port8_rd)
    );

    ppfs_pad #(.W(PCW)) u_portc (
        .dir(portc_direction_reg), .pu(portc_pullup_select_reg),
        .dout(portc_data_reg), .alt_osel({PCW{1'b0}}), .alt_isel({PCW{1'b0}}),
        .alt_out({PCW{1'b0}}), .alt_in(), .pin_in(portc_pin_in), .pin_out(portc_pin_out),
        .pin_oe(portc_pin_oe), .pin_pu(portc_pin_pu), .rd_val(portc_rd)
    );

endmodule // ppfs_top

`default_nettype wire

// File: hw/ppfs_map.vh
// Purpose: register offsets, reset value and port c field position of the pin function select block
// Assumes: wishbone byte addresses, one aligned 32-bit word per register
// Notes:   port data sits in the low bits of each word; port c uses bits 7:2
`ifndef PPFS_MAP_VH
`define PPFS_MAP_VH

`define PPFS_P0_OUT 8'h00
`define PPFS_P0_DIR 8'h04
`define PPFS_P0_PLU 8'h08
`define PPFS_P0_IN  8'h0c
`define PPFS_P0_MD  8'h10
`define PPFS_P2_OUT 8'h20
`define PPFS_P2_DIR 8'h24
`define PPFS_P2_PLU 8'h28
`define PPFS_P2_IN  8'h2c
`define PPFS_P2_MD  8'h30
`define PPFS_P4_OUT 8'h40
`define PPFS_P4_DIR 8'h44
`define PPFS_P4_PLU 8'h48
`define PPFS_P4_IN  8'h4c
`define PPFS_P4_MD1 8'h50
`define PPFS_P4_MD2 8'h54
`define PPFS_P6_OUT 8'h60
`define PPFS_P6_DIR 8'h64
`define PPFS_P6_PLU 8'h68
`define PPFS_P6_IN  8'h6c
`define PPFS_P8_OUT 8'h80
`define PPFS_P8_DIR 8'h84
`define PPFS_P8_PLU 8'h88
`define PPFS_P8_IN  8'h8c
`define PPFS_PC_OUT 8'hc0
`define PPFS_PC_DIR 8'hc4
`define PPFS_PC_PLU 8'hc8
`define PPFS_PC_IN  8'hcc

// reset: input direction, pull-ups off, no alternate function
`define PPFS_RST_VAL     8'h00
// lowest port c bit
`define PPFS_PC_LSB      2

`endif

// File: hw/ppfs_pad.v
// Purpose: per-bit pin cell group: direction, pull-up, data latch, alternate function
// Assumes: pin inputs synchronous to sys_clk
// Notes:   pull-up only applied while the bit is an input
`default_nettype none

module ppfs_pad #(
    parameter W = 2
) (
    // configuration
    input  wire [W-1:0] dir,
    input  wire [W-1:0] pu,
    input  wire [W-1:0] dout,
    input  wire [W-1:0] alt_osel,
    input  wire [W-1:0] alt_isel,
    // peripheral side
    input  wire [W-1:0] alt_out,
    output wire [W-1:0] alt_in,
    // pin side
    input  wire [W-1:0] pin_in,
    output wire [W-1:0] pin_out,
    output wire [W-1:0] pin_oe,
    output wire [W-1:0] pin_pu,
    // software read value
    output wire [W-1:0] rd_val
);

    assign pin_oe  = dir;
    assign pin_out = (alt_osel & dir & alt_out) | (~alt_osel & dout);
    assign pin_pu  = pu & ~dir;
    assign alt_in  = alt_isel & ~dir & pin_in;
    assign rd_val  = (dir & dout) | (~dir & pin_in);

endmodule // ppfs_pad

`default_nettype wire

// File: hw/ppfs_wb_ack.v
// Purpose: classic wishbone single-cycle answer timing
// Assumes: master holds request until it samples ack
// Notes:   ack one cycle after request; write strobe at the ack edge
`default_nettype none

module ppfs_wb_ack (
    // clock and reset
    input  wire sys_clk,
    input  wire rstn,
    // bus request
    input  wire cyc,
    input  wire stb,
    input  wire we,
    input  wire sel0,
    // answer and strobes
    output wire ack,
    output wire load,
    output wire wr_en
);

    reg ack_reg;
    wire req;

    assign req   = cyc & stb;
    assign ack   = ack_reg;
    assign load  = req & ~ack_reg;
    assign wr_en = req & we & sel0 & ack_reg;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

endmodule // ppfs_wb_ack

`default_nettype wire

// File: tb/ppfs_top_properties.sv
// Purpose: port-level properties of the pin function select block
// Assumes: bound to ppfs_top, one clock domain
// Notes:   sees top ports only
`default_nettype none
module ppfs_checker #(
    parameter P0W = 4, P2W = 6, P4W = 2, P6W = 2, P8W = 6, PCW = 6
) (
    // clock, reset, bus
    input wire logic           sys_clk,
    input wire logic           rstn,
    input wire logic           wb_cyc_i,
    input wire logic           wb_stb_i,
    input wire logic           wb_we_i,
    input wire logic [3:0]     wb_sel_i,
    input wire logic           wb_ack_o,
    // pin controls
    input wire logic [P0W-1:0] port0_pin_oe,
    input wire logic [P0W-1:0] port0_pin_pu,
    input wire logic [P2W-1:0] port2_pin_oe,
    input wire logic [P2W-1:0] port2_pin_pu,
    input wire logic [P4W-1:0] port4_pin_oe,
    input wire logic [P4W-1:0] port4_pin_pu,
    input wire logic [P6W-1:0] port6_pin_oe,
    input wire logic [P6W-1:0] port6_pin_pu,
    input wire logic [P8W-1:0] port8_pin_oe,
    input wire logic [P8W-1:0] port8_pin_pu,
    input wire logic [PCW-1:0] portc_pin_oe,
    input wire logic [PCW-1:0] portc_pin_pu,
    // alternate inputs
    input wire logic           serial_rx_in_ch0,
    input wire logic           serial_rx_in_ch1,
    input wire logic           serial_clock_io_ch0_in,
    input wire logic           serial_clock_io_ch1_in,
    input wire logic [5:0]     timer_event_in
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    reset_pins_input_a: assert property (!$past(rstn) |->
        port6_pin_oe == 0 && port6_pin_pu == 0 && port8_pin_oe == 0 && port8_pin_pu == 0
        && portc_pin_oe == 0 && portc_pin_pu == 0) else $error("pins not input after reset");
    pullup_input_only_a: assert property ((port0_pin_pu & port0_pin_oe) == 0
        && (port2_pin_pu & port2_pin_oe) == 0 && (port4_pin_pu & port4_pin_oe) == 0
        && (port6_pin_pu & port6_pin_oe) == 0 && (port8_pin_pu & port8_pin_oe) == 0
        && (portc_pin_pu & portc_pin_oe) == 0) else $error("pull-up on driving pin");
    rx_gated_input_a: assert property ((serial_rx_in_ch0 |-> !port2_pin_oe[2])
        and (serial_rx_in_ch1 |-> !port2_pin_oe[5])) else $error("rx fed from output pin");
    clock_gated_input_a: assert property ((serial_clock_io_ch0_in |-> !port2_pin_oe[1])
        and (serial_clock_io_ch1_in |-> !port2_pin_oe[4])) else $error("clock in on output");
    event_gated_input_a: assert property (
        (timer_event_in & {port4_pin_oe, port0_pin_oe}) == 0) else $error("event on output");
    dir_change_write_a: assert property ($changed({port0_pin_oe, port2_pin_oe,
        port4_pin_oe, port6_pin_oe, port8_pin_oe, portc_pin_oe})
        |-> $past(wb_ack_o && wb_we_i && wb_sel_i[0])) else $error("direction moved alone");
endmodule // ppfs_checker

bind ppfs_top ppfs_checker #(.P0W(P0W), .P2W(P2W), .P4W(P4W), .P6W(P6W), .P8W(P8W),
    .PCW(PCW)) ppfs_checker_i (.*);
`default_nettype wire

// File: tb/ppfs_board.sv
// Purpose: board side of one port: pin level from device, board driver, pull-up
// Assumes: a floating pin has no defined level
// Notes:   floating pin flips every cycle
`default_nettype none
module ppfs_board #(
    parameter int W = 6
) (
    // clock
    input  wire logic         sys_clk,
    // device pin
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe,
    input  wire logic [W-1:0] pin_pu,
    // board driver
    input  wire logic [W-1:0] drv_en,
    input  wire logic [W-1:0] drv_val,
    output logic      [W-1:0] level
);
    logic [W-1:0] held_reg;
    always_comb begin
        for (int i = 0; i < W; i++)
            level[i] = (pin_oe[i] === 1'b1) ? pin_out[i] : (drv_en[i] === 1'b1) ? drv_val[i]
                : (pin_pu[i] === 1'b1) ? 1'b1 : ~held_reg[i];
    end
    always_ff @(posedge sys_clk) begin
        held_reg <= level;
    end
endmodule // ppfs_board
`default_nettype wire

// File: tb/ppfs_top_test.sv
// Purpose: self-checking bench of the pin function select block
// Assumes: ack one cycle after request, pins combinational
// Notes:   port index 0..5 is port 0,2,4,6,8,c
`default_nettype none
`include "ppfs_map.vh"
module ppfs_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, rx0, rx1, ci0, ci1;
    wire  [5:0]  oe_v [6], pu_v [6], out_v [6], lvl [6], ev;
    logic [5:0]  drv_en [6], drv_val [6], pulse;
    logic        tx0, tx1, ck0, ck1;
    int          n_mismatch, checked;
    localparam logic [7:0] BASE [6] = '{`PPFS_P0_OUT, `PPFS_P2_OUT, `PPFS_P4_OUT,
        `PPFS_P6_OUT, `PPFS_P8_OUT, `PPFS_PC_OUT};
    localparam logic [5:0] MSK [6] = '{6'hf, 6'h3f, 6'h3, 6'h3, 6'h3f, 6'h3f};

    ppfs_top ppfs_top_i (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .port0_pin_in(lvl[0][3:0]), .port0_pin_out(out_v[0][3:0]),
        .port0_pin_oe(oe_v[0][3:0]), .port0_pin_pu(pu_v[0][3:0]), .port2_pin_in(lvl[1]),
        .port2_pin_out(out_v[1]), .port2_pin_oe(oe_v[1]), .port2_pin_pu(pu_v[1]),
        .port4_pin_in(lvl[2][1:0]), .port4_pin_out(out_v[2][1:0]),
        .port4_pin_oe(oe_v[2][1:0]), .port4_pin_pu(pu_v[2][1:0]),
        .port6_pin_in(lvl[3][1:0]), .port6_pin_out(out_v[3][1:0]),
        .port6_pin_oe(oe_v[3][1:0]), .port6_pin_pu(pu_v[3][1:0]), .port8_pin_in(lvl[4]),
        .port8_pin_out(out_v[4]), .port8_pin_oe(oe_v[4]), .port8_pin_pu(pu_v[4]),
        .portc_pin_in(lvl[5]), .portc_pin_out(out_v[5]), .portc_pin_oe(oe_v[5]),
        .portc_pin_pu(pu_v[5]), .serial_tx_out_ch0(tx0), .serial_tx_out_ch1(tx1),
        .serial_rx_in_ch0(rx0), .serial_rx_in_ch1(rx1), .serial_clock_io_ch0_out(ck0),
        .serial_clock_io_ch1_out(ck1), .serial_clock_io_ch0_in(ci0),
        .serial_clock_io_ch1_in(ci1), .timer_pulse_out(pulse), .timer_event_in(ev));

    for (genvar g = 0; g < 6; g++) begin : brd
        ppfs_board ppfs_board_i (.sys_clk(sys_clk), .pin_out(out_v[g]), .pin_oe(oe_v[g]),
            .pin_pu(pu_v[g]), .drv_en(drv_en[g]), .drv_val(drv_val[g]), .level(lvl[g]));
    end

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    function automatic logic [5:0] sel_mux(input logic [5:0] s, a, l);
        return (s & a) | (~s & l);
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cmp_reg(input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic [5:0] got, exp);
        cmp_reg({26'h0, got}, {26'h0, exp});
    endtask

    // one classic cycle; hold until ack sampled, then idle one cycle
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            stop_test();
        end
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    task automatic reset_chk();
        logic [31:0] q;
        for (int p = 0; p < 6; p++) begin
            cmp_pin(oe_v[p] & MSK[p], 6'h0);
            cmp_pin(pu_v[p] & MSK[p], 6'h0);
            rd(BASE[p] + 8'h04, q);
            cmp_reg(q, 32'h0);
            rd(BASE[p] + 8'h08, q);
            cmp_reg(q, 32'h0);
        end
        $display("test reset done");
    endtask

    task automatic gpio_t();
        logic [5:0] d, u, o, v;
        logic [31:0] q;
        int s;
        for (int k = 0; k < 6; k++) begin
            for (int p = 0; p < 6; p++) begin
                s = (p == 5) ? `PPFS_PC_LSB : 0;
                d = 6'($urandom) & MSK[p];
                u = 6'($urandom) & MSK[p];
                o = 6'($urandom) & MSK[p];
                v = 6'($urandom);
                drv_val[p] <= v;
                wr(BASE[p] + 8'h08, 32'(u) << s);
                wr(BASE[p] + 8'h04, 32'(d) << s);
                wr(BASE[p], 32'(o) << s);
                cmp_pin(oe_v[p] & MSK[p], d);
                cmp_pin(pu_v[p] & MSK[p], u & ~d);
                cmp_pin(out_v[p] & d, o & d);
                rd(BASE[p] + 8'h0c, q);
                cmp_reg(q, 32'(sel_mux(d, o, v) & MSK[p]) << s);
            end
        end
        drv_en[3] <= 6'h0;
        wr(`PPFS_P6_DIR, 32'h0);
        wr(`PPFS_P6_PLU, 32'h3);
        rd(`PPFS_P6_IN, q);
        cmp_reg(q, 32'h3);
        drv_en[3] <= 6'h3f;
        wr(8'hf0, 32'hff);
        rd(8'hf0, q);
        cmp_reg(q, 32'h0);
        wr(`PPFS_P6_DIR, 32'h1);
        wb_sel_i <= 4'he;
        wr(`PPFS_P6_DIR, 32'h2);
        wb_sel_i <= 4'hf;
        cmp_pin(oe_v[3] & 6'h3, 6'h1);
        $display("test gpio done");
    endtask

    task automatic alt_t();
        logic [5:0] m, n, d, o, v, u, t;
        for (int k = 0; k < 12; k++) begin
            {m, n, d, o, v, u} = 36'({$urandom, $urandom});
            {tx0, tx1, ck0, ck1} <= 4'($urandom);
            pulse <= 6'($urandom);
            drv_val[0] <= {2'h0, v[3:0]};
            drv_val[1] <= v;
            drv_val[2] <= {4'h0, v[5:4]};
            wr(`PPFS_P2_MD, 32'(m));
            wr(`PPFS_P2_DIR, 32'(d));
            wr(`PPFS_P2_OUT, 32'(o));
            t = sel_mux(m & 6'h1b, {1'b0, ck1, tx1, 1'b0, ck0, tx0}, o);
            cmp_pin(out_v[1] & d, t & d);
            t = m & ~d & v;
            cmp_pin({rx1, ci1, rx0, ci0}, {t[5], t[4], t[2], t[1]});
            wr(`PPFS_P0_MD, 32'(m[3:0]));
            wr(`PPFS_P4_MD1, 32'(m[5:4]));
            wr(`PPFS_P4_MD2, 32'(n[5:4]));
            wr(`PPFS_P0_DIR, 32'(d[3:0]));
            wr(`PPFS_P4_DIR, 32'(d[5:4]));
            wr(`PPFS_P0_PLU, 32'(u[3:0]));
            wr(`PPFS_P4_PLU, 32'(u[5:4]));
            t = sel_mux({m[5:4] & n[5:4], m[3:0]}, pulse, {o[1:0], o[3:0]});
            wr(`PPFS_P0_OUT, 32'(o[3:0]));
            wr(`PPFS_P4_OUT, 32'(o[1:0]));
            cmp_pin({out_v[2][1:0], out_v[0][3:0]} & d, t & d);
            cmp_pin(ev, m & ~d & v);
            cmp_pin({pu_v[2][1:0], pu_v[0][3:0]}, u & ~d);
        end
        $display("test alt done");
    endtask

    initial begin
        {rstn, wb_cyc_i, wb_stb_i, wb_we_i, tx0, tx1, ck0, ck1} = 8'h0;
        {wb_adr_i, wb_dat_i, pulse} = 46'h0;
        wb_sel_i = 4'hf;
        drv_en = '{6{6'h3f}};
        drv_val = '{6{6'h0}};
        void'($urandom(8388));
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        reset_chk();
        gpio_t();
        alt_t();
        rstn <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        reset_chk();
        stop_test();
    end
endmodule // ppfs_top_test
`default_nettype wire
